//--- wd_pkg.sv
// Constants, field layouts and carrier types for the window watchdog
package wd_pkg;

  // Timing
  localparam int unsigned CLK_FREQ_HZ = 200_000_000;
  localparam int unsigned RC_OSC_FREQ_HZ = 32_000;
  localparam int unsigned OSC_TICK_CYC = CLK_FREQ_HZ / RC_OSC_FREQ_HZ;

  // Counter chain widths and terminals
  localparam int unsigned PRE_W = 7;
  localparam int unsigned POST_W = 15;
  localparam int unsigned ELAPSED_W = 23;
  localparam int unsigned PRE_SHIFT_DIV32 = 5;
  localparam int unsigned PRE_SHIFT_DIV128 = 7;
  localparam logic [6:0] PRE_TERM_DIV32 = 7'h1f;
  localparam logic [6:0] PRE_TERM_DIV128 = 7'h7f;

  // Register offsets (byte addresses)
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_RCTL = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;

  // Configuration word fields
  localparam int unsigned CFG_POST_LSB = 0;
  localparam int unsigned CFG_PRE_BIT = 4;
  localparam int unsigned CFG_WIN_DIS_BIT = 6;
  localparam int unsigned CFG_HARDEN_BIT = 7;

  // Reset-control register fields
  localparam int unsigned RCTL_IDLE_BIT = 2;
  localparam int unsigned RCTL_SLEEP_BIT = 3;
  localparam int unsigned RCTL_TIMEOUT_BIT = 4;
  localparam int unsigned RCTL_SOFTEN_BIT = 5;

  // Status register fields
  localparam int unsigned STAT_PRE_LSB = 0;
  localparam int unsigned STAT_POST_LSB = 8;
  localparam int unsigned STAT_WIN_BIT = 24;
  localparam int unsigned STAT_EN_BIT = 25;

  // Reset values of the configuration word
  localparam logic RST_HARD_EN = 1'b0;
  localparam logic RST_WIN_DIS = 1'b1;
  localparam logic RST_PRE_SEL = 1'b1;
  localparam logic [3:0] RST_POST_SEL = 4'hf;

  typedef struct packed {
    logic hard_en;
    logic win_dis;
    logic pre_sel;
    logic [3:0] post_sel;
  } wd_cfg_t;

  typedef enum logic [2:0] {
    PM_RUN = 3'b001,
    PM_SLEEP = 3'b010,
    PM_IDLE = 3'b100
  } pm_state_t;

endpackage

//--- wd_low_power_rc_osc_osc.sv
// Low-power RC oscillator model: one tick per nominal 32 kHz period
`timescale 1ns/10ps
module low_power_rc_osc #(
  parameter int unsigned TICK_CYC = wd_pkg::OSC_TICK_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  output logic tick_o
);
  import wd_pkg::*;

  localparam int unsigned CW = $clog2(TICK_CYC + 1);

  logic [CW-1:0] cnt_r;

  // Oscillator stops whenever nobody needs it, saving power
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !run_i)
    begin
      cnt_r <= '0;
      tick_o <= 1'b0;
    end
    else if (cnt_r == CW'(TICK_CYC - 1))
    begin
      cnt_r <= '0;
      tick_o <= 1'b1;
    end
    else
    begin
      cnt_r <= cnt_r + CW'(1);
      tick_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_tick_needs_run: assert property (@(posedge clk_i) disable iff (rst_i)
    tick_o |-> $past(run_i))
    else $error("oscillator ticked while stopped");

  a_tick_restart: assert property (@(posedge clk_i) disable iff (rst_i)
    tick_o |-> cnt_r == '0)
    else $error("tick without counter wrap");

  c_osc_tick: cover property (@(posedge clk_i) disable iff (rst_i) tick_o);

endmodule

//--- wd_window_watchdog.sv
// Window watchdog with prescaler, power-of-two postscaler and Wishbone registers
//
// Chosen here: the Wishbone slave port and the register offsets.
`timescale 1ns/10ps
module wd_window_watchdog #(
  parameter int unsigned OSC_TICK_CYC = wd_pkg::OSC_TICK_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [wd_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic wd_clear_instr_i,
  input wire logic power_save_instr_i,
  input wire logic power_save_idle_i,
  input wire logic clk_switch_done_i,
  input wire logic wake_src_i,
  output logic wd_reset_o,
  output logic wd_wake_o,
  output logic osc_run_o,
  output logic sleep_o,
  output logic idle_o
);
  import wd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  function automatic logic [PRE_W-1:0] pre_term_f(input logic pre_sel);
    pre_term_f = pre_sel ? PRE_TERM_DIV128 : PRE_TERM_DIV32;
  endfunction

  function automatic logic [POST_W-1:0] post_term_f(input logic [3:0] sel);
    logic [POST_W:0] full;
    full = (POST_W + 1)'(1) << sel;
    post_term_f = POST_W'(full - (POST_W + 1)'(1));
  endfunction

  function automatic logic [ELAPSED_W-1:0] elapsed_f(input logic pre_sel,
      input logic [POST_W-1:0] post, input logic [PRE_W-1:0] pre);
    logic [ELAPSED_W-1:0] p;
    p = {{(ELAPSED_W - POST_W){1'b0}}, post};
    p = pre_sel ? (p << PRE_SHIFT_DIV128) : (p << PRE_SHIFT_DIV32);
    elapsed_f = p | {{(ELAPSED_W - PRE_W){1'b0}}, pre};
  endfunction

  function automatic logic [ELAPSED_W-1:0] thresh_f(input logic pre_sel,
      input logic [3:0] sel);
    logic [ELAPSED_W-1:0] total;
    total = ELAPSED_W'(1) << sel;
    total = pre_sel ? (total << PRE_SHIFT_DIV128) : (total << PRE_SHIFT_DIV32);
    thresh_f = total - (total >> 2);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  wd_cfg_t cfg_r;
  pm_state_t pm_r;
  logic soft_en_r;
  logic wd_timeout_flag_r;
  logic sleep_flag_r;
  logic idle_flag_r;
  logic [PRE_W-1:0] pre_cnt_r;
  logic [POST_W-1:0] post_cnt_r;
  logic ack_r;
  logic [31:0] dat_r;
  logic wd_reset_r;
  logic wake_r;

  logic wd_en;
  logic tick;
  logic pm_run;
  logic pre_tc;
  logic post_tc;
  logic win_open;
  logic timeout;
  logic clr_req;
  logic early_clr;
  logic ps_enter;
  logic wake_exit;
  logic chain_clr;
  logic bus_req;
  logic bus_wr;
  logic [31:0] rd_data;

  assign wd_en = cfg_r.hard_en | soft_en_r;
  assign osc_run_o = wd_en;
  assign pm_run = pm_r[0];
  assign sleep_o = pm_r[1];
  assign idle_o = pm_r[2];
  assign pre_tc = (pre_cnt_r == pre_term_f(cfg_r.pre_sel));
  assign post_tc = (post_cnt_r == post_term_f(cfg_r.post_sel));
  assign win_open = elapsed_f(cfg_r.pre_sel, post_cnt_r, pre_cnt_r)
    >= thresh_f(cfg_r.pre_sel, cfg_r.post_sel);
  assign timeout = wd_en & tick & pre_tc & post_tc;
  assign clr_req = wd_clear_instr_i & pm_run;
  assign early_clr = clr_req & wd_en & ~cfg_r.win_dis & ~win_open;
  assign ps_enter = power_save_instr_i & pm_run;
  assign wake_exit = ~pm_run & (wake_src_i | timeout);
  // Disabled watchdog holds the chain at zero so a re-enable starts fresh
  assign chain_clr = ~wd_en | clk_switch_done_i | ps_enter | wake_exit
    | clr_req | timeout;
  assign wd_reset_o = wd_reset_r;
  assign wd_wake_o = wake_r;

  low_power_rc_osc #(
    .TICK_CYC(OSC_TICK_CYC)
  ) u_osc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(wd_en),
    .tick_o(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Counter chain

  // Prescaler terminal of 32 ticks at 32 kHz gives 1 ms; 128 gives 4 ms
  always_ff @(posedge clk_i)
  begin
    if (rst_i || chain_clr)
      pre_cnt_r <= '0;
    else if (tick)
      pre_cnt_r <= pre_tc ? '0 : pre_cnt_r + PRE_W'(1);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || chain_clr)
      post_cnt_r <= '0;
    else if (tick && pre_tc)
      post_cnt_r <= post_cnt_r + POST_W'(1);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power mode

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pm_r <= PM_RUN;
    else
      case (pm_r)
        PM_RUN:
          if (power_save_instr_i)
            pm_r <= power_save_idle_i ? PM_IDLE : PM_SLEEP;
        PM_SLEEP, PM_IDLE:
          if (wake_src_i || timeout)
            pm_r <= PM_RUN;
        default:
          pm_r <= PM_RUN;
      endcase
  end

  // Event pulses; the system reset controller acts on wd_reset_o
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wd_reset_r <= 1'b0;
      wake_r <= 1'b0;
    end
    else
    begin
      wd_reset_r <= (timeout & pm_run) | early_clr;
      wake_r <= timeout & ~pm_run;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave, one wait state; writes commit on the acknowledged edge

  assign bus_req = wb_cyc_i & wb_stb_i;
  assign bus_wr = bus_req & ack_r & wb_we_i & wb_sel_i[0];
  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  always_comb
  begin
    rd_data = 32'h0;
    case (wb_adr_i)
      ADDR_CFG:
      begin
        rd_data[CFG_POST_LSB +: 4] = cfg_r.post_sel;
        rd_data[CFG_PRE_BIT] = cfg_r.pre_sel;
        rd_data[CFG_WIN_DIS_BIT] = cfg_r.win_dis;
        rd_data[CFG_HARDEN_BIT] = cfg_r.hard_en;
      end
      ADDR_RCTL:
      begin
        rd_data[RCTL_IDLE_BIT] = idle_flag_r;
        rd_data[RCTL_SLEEP_BIT] = sleep_flag_r;
        rd_data[RCTL_TIMEOUT_BIT] = wd_timeout_flag_r;
        rd_data[RCTL_SOFTEN_BIT] = soft_en_r;
      end
      ADDR_STAT:
      begin
        rd_data[STAT_PRE_LSB +: PRE_W] = pre_cnt_r;
        rd_data[STAT_POST_LSB +: POST_W] = post_cnt_r;
        rd_data[STAT_WIN_BIT] = win_open;
        rd_data[STAT_EN_BIT] = wd_en;
      end
      default:
        rd_data = 32'h0;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_r <= 1'b0;
      dat_r <= 32'h0;
    end
    else
    begin
      ack_r <= bus_req & ~ack_r;
      if (bus_req && !ack_r)
        dat_r <= rd_data;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cfg_r <= '{hard_en: RST_HARD_EN, win_dis: RST_WIN_DIS,
        pre_sel: RST_PRE_SEL, post_sel: RST_POST_SEL};
    else if (bus_wr && wb_adr_i == ADDR_CFG)
    begin
      cfg_r.post_sel <= wb_dat_i[CFG_POST_LSB +: 4];
      cfg_r.pre_sel <= wb_dat_i[CFG_PRE_BIT];
      cfg_r.win_dis <= wb_dat_i[CFG_WIN_DIS_BIT];
      cfg_r.hard_en <= wb_dat_i[CFG_HARDEN_BIT];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      soft_en_r <= 1'b0;
    else if (bus_wr && wb_adr_i == ADDR_RCTL)
      soft_en_r <= wb_dat_i[RCTL_SOFTEN_BIT];
  end

  // Flags clear on a written 0; a hardware set in the same cycle wins
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wd_timeout_flag_r <= 1'b0;
    else if (timeout || early_clr)
      wd_timeout_flag_r <= 1'b1;
    else if (bus_wr && wb_adr_i == ADDR_RCTL && !wb_dat_i[RCTL_TIMEOUT_BIT])
      wd_timeout_flag_r <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sleep_flag_r <= 1'b0;
      idle_flag_r <= 1'b0;
    end
    else
    begin
      // Left set after wake-up; software owns the clear
      if (ps_enter && !power_save_idle_i)
        sleep_flag_r <= 1'b1;
      else if (bus_wr && wb_adr_i == ADDR_RCTL && !wb_dat_i[RCTL_SLEEP_BIT])
        sleep_flag_r <= 1'b0;
      if (ps_enter && power_save_idle_i)
        idle_flag_r <= 1'b1;
      else if (bus_wr && wb_adr_i == ADDR_RCTL && !wb_dat_i[RCTL_IDLE_BIT])
        idle_flag_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_osc_forced_on: assert property (cfg_r.hard_en |-> osc_run_o)
    else $error("hard enable did not force the oscillator");
  a_prescale_wrap: assert property (tick && pre_tc && !chain_clr |=>
    pre_cnt_r == '0 && $past(pre_cnt_r) == (cfg_r.pre_sel ? 7'h7f : 7'h1f))
    else $error("prescaler wrapped at wrong count");
  a_timeout_term: assert property (timeout |->
    post_cnt_r == POST_W'((32'h1 << cfg_r.post_sel) - 32'h1))
    else $error("timeout at wrong postscale count");
  a_clear_chain: assert property (clr_req || clk_switch_done_i || ps_enter
    |=> pre_cnt_r == '0 && post_cnt_r == '0)
    else $error("chain not cleared");
  a_wake_sleep: assert property (timeout && !pm_run |=>
    pm_run && wd_wake_o && !wd_reset_o && pre_cnt_r == '0)
    else $error("timeout in power save did not wake");
  a_soft_gate: assert property (!cfg_r.hard_en && !soft_en_r |=>
    pre_cnt_r == '0 && !tick)
    else $error("disabled watchdog counted");
  a_flag_sticky: assert property (wd_timeout_flag_r && !(bus_wr && wb_adr_i == ADDR_RCTL)
    |=> wd_timeout_flag_r)
    else $error("timeout flag dropped on its own");
  a_run_reset: assert property (timeout && pm_run |=> wd_reset_o && wd_timeout_flag_r)
    else $error("run timeout gave no reset");
  a_early_reset: assert property (clr_req && wd_en && !cfg_r.win_dis
    && elapsed_f(cfg_r.pre_sel, post_cnt_r, pre_cnt_r)
      < thresh_f(cfg_r.pre_sel, cfg_r.post_sel) |=> wd_reset_o)
    else $error("early clear gave no reset");
  a_late_clear_ok: assert property (clr_req && !timeout && (cfg_r.win_dis || win_open)
    |=> !wd_reset_o)
    else $error("permitted clear caused reset");
  a_soft_reset: assert property ($fell(rst_i) |-> !soft_en_r)
    else $error("soft enable survived reset");

  c_run_timeout: cover property (timeout && pm_run);
  c_sleep_wake: cover property (timeout && pm_r == PM_SLEEP);
  c_early_clear: cover property (early_clr);
  c_window_clear: cover property (clr_req && !cfg_r.win_dis && win_open);

endmodule

//--- wd_core_model.sv
// Processor core model that issues clear, power-save, clock-switch and wake events
`timescale 1ns/10ps
module wd_core_model (
  input wire logic clk_i,
  input wire logic wd_wake_i,
  output logic clear_o,
  output logic ps_o,
  output logic ps_idle_o,
  output logic sw_done_o,
  output logic wake_o
);
  logic asleep = 1'b0;

  initial {clear_o, ps_o, ps_idle_o, sw_done_o, wake_o} = '0;

  ////////////////////////////////////////////////////////////////////////////////
  // A sleeping core runs no code, so it issues no instruction
  always @(posedge clk_i)
  begin
    if (wd_wake_i)
      asleep <= 1'b0;
  end

  // Kind 0 clear, 1 power save, 2 clock switch done, 3 other wake source
  task ev(input int k, input logic idle);
    @(posedge clk_i);
    if (k == 0 && !asleep)
      clear_o <= 1'b1;
    if (k == 1 && !asleep)
    begin
      {ps_o, ps_idle_o} <= {1'b1, idle};
      asleep = 1'b1;
    end
    if (k == 2)
      sw_done_o <= 1'b1;
    if (k == 3)
    begin
      wake_o <= 1'b1;
      asleep = 1'b0;
    end
    @(posedge clk_i);
    {clear_o, ps_o, ps_idle_o, sw_done_o, wake_o} <= '0;
  endtask
endmodule

//--- testbench.sv
// Self-checking bench for the window watchdog
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module testbench;
  import wd_pkg::*;
  // Short oscillator tick keeps the run brief; periods scale from it
  localparam int TK = 4;
  localparam int P = 32 * TK;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] adr = '0;
  logic [31:0] wdat = '0;
  logic [31:0] q;
  logic [31:0] rdat;
  logic [3:0] sel = '0;
  logic we = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic ack, clr, ps, psi, swd, wk, wrst, wwake, lrun, slp, idl;
  int err_count = 0;
  int comparisons = 0;

  always #2.5 clk_i = ~clk_i;

  wd_window_watchdog #(.OSC_TICK_CYC(TK)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
    .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack),
    .wd_clear_instr_i(clr), .power_save_instr_i(ps), .power_save_idle_i(psi),
    .clk_switch_done_i(swd), .wake_src_i(wk), .wd_reset_o(wrst), .wd_wake_o(wwake),
    .osc_run_o(lrun), .sleep_o(slp), .idle_o(idl));

  wd_core_model u_core (
    .clk_i(clk_i), .wd_wake_i(wwake), .clear_o(clr), .ps_o(ps), .ps_idle_o(psi),
    .sw_done_o(swd), .wake_o(wk));

  ////////////////////////////////////////////////////////////////////////////////
  task print_verdict();
    if (err_count == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Classic cycle held until ack is sampled high at a rising edge
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, 4'hf};
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    `CHK(ack, 1'b1)
    q = rdat;
    {cyc, stb} <= 2'b00;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    `CHK(q, e)
  endtask

  // Cycles until a reset or wake pulse, sampled after each edge settles
  task cnt(input int lim, output int n);
    n = 0;
    while (wrst !== 1'b1 && wwake !== 1'b1 && n < lim)
    begin
      @(posedge clk_i);
      #1;
      n++;
    end
  endtask

  // Oscillator tick phase is free, so allow a few cycles either way
  task near(input int n, input int e);
    `CHK(n >= e - 4 && n <= e + 8, 1'b1)
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task t_reset();
    int n;
    rd(ADDR_CFG, 32'h5f);
    rd(ADDR_RCTL, 32'h0);
    rd(ADDR_STAT, 32'h0);
    wb(1'b1, 8'h0c, 32'hff);
    rd(8'h0c, 32'h0);
    `CHK(lrun, 1'b0);
    cnt(300, n);
    `CHK(n, 300);
  endtask

  task t_period();
    int n;
    logic [7:0] tbl [5];
    tbl = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h10};
    foreach (tbl[i])
    begin
      wb(1'b1, ADDR_CFG, {24'h0, tbl[i] | 8'h40});
      wb(1'b1, ADDR_RCTL, 32'h20);
      cnt(20000, n);
      near(n, ((tbl[i][4] ? 128 : 32) * TK) << tbl[i][3:0]);
      `CHK(wrst, 1'b1);
      `CHK(lrun, 1'b1);
      rd(ADDR_RCTL, 32'h30);
      wb(1'b1, ADDR_RCTL, 32'h30);
      rd(ADDR_RCTL, 32'h30);
      wb(1'b1, ADDR_RCTL, 32'h0);
      rd(ADDR_RCTL, 32'h0);
    end
  endtask

  task t_restart();
    int n;
    wb(1'b1, ADDR_CFG, 32'h40);
    wb(1'b1, ADDR_RCTL, 32'h20);
    for (int k = 0; k < 2; k++)
    begin
      repeat (90) @(posedge clk_i);
      u_core.ev(k * 2, 1'b0);
      cnt(400, n);
      near(n, P);
    end
    wb(1'b1, ADDR_RCTL, 32'h0);
  endtask

  task t_window();
    int n;
    wb(1'b1, ADDR_CFG, 32'h00);
    wb(1'b1, ADDR_RCTL, 32'h20);
    repeat (80) @(posedge clk_i);
    u_core.ev(0, 1'b0);
    #1;
    `CHK(wrst, 1'b1);
    rd(ADDR_RCTL, 32'h30);
    wb(1'b1, ADDR_RCTL, 32'h0);
    wb(1'b1, ADDR_RCTL, 32'h20);
    repeat (110) @(posedge clk_i);
    u_core.ev(0, 1'b0);
    #1;
    cnt(20, n);
    `CHK(n, 20);
    cnt(400, n);
    near(n, P - 20);
    wb(1'b1, ADDR_RCTL, 32'h0);
  endtask

  task t_hard();
    int n;
    wb(1'b1, ADDR_CFG, 32'hc0);
    cnt(400, n);
    near(n, P);
    `CHK(lrun, 1'b1);
    rd(ADDR_RCTL, 32'h10);
    wb(1'b1, ADDR_CFG, 32'h40);
    wb(1'b1, ADDR_RCTL, 32'h0);
  endtask

  task t_sleep();
    int n;
    for (int i = 0; i < 2; i++)
    begin
      wb(1'b1, ADDR_CFG, 32'h40);
      wb(1'b1, ADDR_RCTL, 32'h20);
      repeat (60) @(posedge clk_i);
      u_core.ev(1, i[0]);
      #1;
      `CHK({slp, idl}, i ? 2'b01 : 2'b10);
      cnt(400, n);
      near(n, P);
      `CHK({wwake, wrst}, 2'b10);
      @(posedge clk_i);
      #1;
      `CHK({slp, idl}, 2'b00);
      rd(ADDR_RCTL, i ? 32'h34 : 32'h38);
      wb(1'b1, ADDR_RCTL, 32'h0);
      rd(ADDR_RCTL, 32'h0);
    end
  endtask

  task t_wake();
    int n;
    wb(1'b1, ADDR_CFG, 32'h40);
    wb(1'b1, ADDR_RCTL, 32'h20);
    u_core.ev(1, 1'b0);
    repeat (100) @(posedge clk_i);
    u_core.ev(3, 1'b0);
    cnt(400, n);
    near(n, P);
    `CHK({wrst, slp}, 2'b10);
    rd(ADDR_RCTL, 32'h38);
    // Mid-run reset must drop the software enable and the whole chain
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(ADDR_RCTL, 32'h0);
    rd(ADDR_STAT, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_period();
    t_restart();
    t_window();
    t_hard();
    t_sleep();
    t_wake();
    print_verdict();
  end

  // Whole run needs well under this span
  initial
  begin
    #200us;
    err_count++;
    print_verdict();
  end
endmodule
